/* srgt_pkg.sv */
// Package with register map, field layout, reset values and timing for the runaway guard timer.
package srgt_pkg;
  localparam int unsigned SRGT_AW = 4;
  localparam int unsigned SRGT_DW = 16;
  localparam int unsigned SRGT_CW = 9;
  // Register offsets.
  localparam logic [3:0] SRGT_OFS_COUNT = 4'h0;
  localparam logic [3:0] SRGT_OFS_CTRL = 4'h1;
  localparam logic [3:0] SRGT_OFS_FRZ_SET = 4'h2;
  localparam logic [3:0] SRGT_OFS_FRZ_CLR = 4'h3;
  localparam logic [3:0] SRGT_OFS_STATE = 4'h4;
  localparam logic [3:0] SRGT_OFS_IRQ_STAT = 4'h5;
  localparam logic [3:0] SRGT_OFS_IRQ_CLR = 4'h6;
  localparam logic [3:0] SRGT_OFS_IRQ_EN = 4'h7;
  localparam logic [3:0] SRGT_OFS_REMAP = 4'h8;
  // Field positions.
  localparam int unsigned SRGT_GUARD_LSB = 9;
  localparam int unsigned SRGT_GUARD_MSB = 15;
  localparam int unsigned SRGT_SIGN_BIT = 8;
  localparam int unsigned SRGT_CTRL_DIRECT_BIT = 0;
  localparam int unsigned SRGT_FRZ_BIT = 0;
  localparam int unsigned SRGT_IRQ_NMI_BIT = 0;
  localparam int unsigned SRGT_IRQ_TICK_BIT = 1;
  localparam int unsigned SRGT_IRQ_W = 2;
  localparam int unsigned SRGT_REMAP_W = 2;
  // Values after reset and thresholds.
  localparam logic [8:0] SRGT_COUNT_RST = 9'h0FF;
  localparam logic [8:0] SRGT_COUNT_NMI = 9'h000;
  localparam logic [8:0] SRGT_COUNT_LAST = 9'h1F0;
  localparam logic [1:0] SRGT_REMAP_RST = 2'h0;
  // Timing.
  localparam int unsigned SRGT_CLK_PERIOD_NS = 10;
  localparam int unsigned SRGT_TICK_PERIOD_US = 10240;
  localparam int unsigned SRGT_TICK_CYCLES = SRGT_TICK_PERIOD_US * 1000 / SRGT_CLK_PERIOD_NS;
endpackage : srgt_pkg

/* srgt_guard_timer.sv */
// Runaway guard timer: 9-bit signed down counter with interrupt and system reset request.
module srgt_guard_timer
  import srgt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = SRGT_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Other system reset sources, same clock.
  input wire logic sys_rst_i,
  // Core debug halt status, same clock.
  input wire logic core_halted_i,
  // Register port.
  input wire logic [SRGT_AW-1:0] addr_i,
  input wire logic [SRGT_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [SRGT_DW-1:0] rdata_o,
  // Events.
  output logic nmi_o,
  output logic sys_rst_req_o,
  output logic irq_o,
  output logic [SRGT_REMAP_W-1:0] boot_remap_bits_o
);

  // The prescaler needs at least two states to tell a tick from its reload.
  if (TICK_CYCLES < 2) begin : g_tick_check
    $error("TICK_CYCLES must be at least 2");
  end

  logic [SRGT_CW-1:0] count_r, count_nxt;
  logic [31:0] presc_r, presc_nxt;
  logic direct_r, direct_nxt;
  logic sw_frz_r, sw_frz_nxt;
  logic [SRGT_IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [SRGT_IRQ_W-1:0] irq_en_r, irq_en_nxt;
  logic [SRGT_REMAP_W-1:0] remap_r, remap_nxt;
  logic [SRGT_DW-1:0] rdata_r, rdata_nxt;
  logic nmi_r, nmi_nxt;
  logic rst_req_r, rst_req_nxt;
  logic irq_r, irq_nxt;
  logic sys_clr, frozen, tick, wr_count, guard_ok, expire;

  // A request issued here comes straight back as a system reset of this block.
  assign sys_clr = rst_req_r | sys_rst_i;
  // Only the core's halt status and the software freeze, which direct mode overrides, stop the count; no other input reaches it.
  assign frozen = core_halted_i | (sw_frz_r & ~direct_r);
  assign tick = (presc_r == 32'h0) & ~frozen;
  assign guard_ok = (wdata_i[SRGT_GUARD_MSB:SRGT_GUARD_LSB] == 7'h00);
  assign wr_count = wr_i & (addr_i == SRGT_OFS_COUNT) & guard_ok;
  // The check uses the registered count, so a software write of a low value fires too.
  assign expire = direct_r ? ($signed(count_r) <= 0)
                           : ($signed(count_r) <= $signed(SRGT_COUNT_LAST));

  // Counter, prescaler and control state.
  always_comb begin
    count_nxt = count_r;
    presc_nxt = presc_r;
    direct_nxt = direct_r;
    sw_frz_nxt = sw_frz_r;
    // The prescaler holds while frozen, so a frozen interval keeps the tick phase.
    if (!frozen) begin
      presc_nxt = (presc_r == 32'h0) ? TICK_CYCLES - 1 : presc_r - 32'h1;
    end
    if (tick) begin
      count_nxt = count_r - 9'h001;
    end
    if (wr_count) begin
      count_nxt = wdata_i[SRGT_CW-1:0];
    end
    if (wr_i && addr_i == SRGT_OFS_CTRL && wdata_i[SRGT_CTRL_DIRECT_BIT]) begin
      direct_nxt = 1'b1;
    end
    if (wr_i && addr_i == SRGT_OFS_FRZ_SET && wdata_i[SRGT_FRZ_BIT] && !direct_r) begin
      sw_frz_nxt = 1'b1;
    end
    if (wr_i && addr_i == SRGT_OFS_FRZ_CLR && wdata_i[SRGT_FRZ_BIT]) begin
      sw_frz_nxt = 1'b0;
    end
    if (sys_clr) begin
      count_nxt = SRGT_COUNT_RST;
      presc_nxt = TICK_CYCLES - 1;
      direct_nxt = 1'b0;
      sw_frz_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_r <= SRGT_COUNT_RST;
      presc_r <= 32'h0;
      direct_r <= 1'b0;
      sw_frz_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      presc_r <= presc_nxt;
      direct_r <= direct_nxt;
      sw_frz_r <= sw_frz_nxt;
    end
  end

  // Event outputs and interrupt status.
  always_comb begin
    // A count write in the tick cycle wins, so no nmi is raised for that tick; the tick status bit is still set.
    nmi_nxt = tick & ~direct_r & (count_r == 9'h001) & ~wr_count & ~sys_clr;
    rst_req_nxt = expire & ~rst_req_r & ~sys_rst_i;
    irq_en_nxt = irq_en_r;
    irq_stat_nxt = irq_stat_r;
    if (wr_i && addr_i == SRGT_OFS_IRQ_EN) begin
      irq_en_nxt = wdata_i[SRGT_IRQ_W-1:0];
    end
    if (wr_i && addr_i == SRGT_OFS_IRQ_CLR) begin
      irq_stat_nxt = irq_stat_nxt & ~wdata_i[SRGT_IRQ_W-1:0];
    end
    // Setting after clearing lets a same-cycle event win.
    irq_stat_nxt[SRGT_IRQ_NMI_BIT] = irq_stat_nxt[SRGT_IRQ_NMI_BIT] | nmi_nxt;
    irq_stat_nxt[SRGT_IRQ_TICK_BIT] = irq_stat_nxt[SRGT_IRQ_TICK_BIT] | (tick & ~sys_clr);
    if (sys_clr) begin
      irq_en_nxt = '0;
      irq_stat_nxt = '0;
    end
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nmi_r <= 1'b0;
      rst_req_r <= 1'b0;
      irq_en_r <= '0;
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      nmi_r <= nmi_nxt;
      rst_req_r <= rst_req_nxt;
      irq_en_r <= irq_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Boot remap bits are cleared by the hardware reset only.
  always_comb begin
    remap_nxt = remap_r;
    if (wr_i && addr_i == SRGT_OFS_REMAP) begin
      remap_nxt = wdata_i[SRGT_REMAP_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      remap_r <= SRGT_REMAP_RST;
    end else begin
      remap_r <= remap_nxt;
    end
  end

  // Read data stand in the cycle after the read strobe and read zero otherwise.
  always_comb begin
    rdata_nxt = '0;
    if (rd_i) begin
      unique case (addr_i)
        SRGT_OFS_COUNT: rdata_nxt[SRGT_CW-1:0] = count_r;
        SRGT_OFS_CTRL: rdata_nxt[SRGT_CTRL_DIRECT_BIT] = direct_r;
        SRGT_OFS_STATE: rdata_nxt[1:0] = {core_halted_i, sw_frz_r & ~direct_r};
        SRGT_OFS_IRQ_STAT: rdata_nxt[SRGT_IRQ_W-1:0] = irq_stat_r;
        SRGT_OFS_IRQ_EN: rdata_nxt[SRGT_IRQ_W-1:0] = irq_en_r;
        SRGT_OFS_REMAP: rdata_nxt[SRGT_REMAP_W-1:0] = remap_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign nmi_o = nmi_r;
  assign sys_rst_req_o = rst_req_r;
  assign irq_o = irq_r;
  assign boot_remap_bits_o = remap_r;

  // Checks run on the registered state and are off while the hardware reset is low.
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_tick_decrement: assert property (
    tick && !wr_count && !sys_clr |=> count_r == $past(count_r) - 9'h001)
    else $error("count did not drop by one on a tick");

  chk_frozen_hold: assert property (
    frozen && !wr_count && !sys_clr |=> count_r == $past(count_r))
    else $error("count moved while frozen");

  chk_guard_reject: assert property (
    wr_i && addr_i == SRGT_OFS_COUNT && !guard_ok && !tick && !sys_clr
      |=> $stable(count_r))
    else $error("guarded write changed the count");

  chk_write_load: assert property (
    wr_count && !sys_clr |=> count_r == $past(wdata_i[8:0]))
    else $error("good count write not loaded");

  chk_nmi_zero: assert property (
    nmi_o |-> count_r == SRGT_COUNT_NMI && !$past(direct_r))
    else $error("nmi without count zero in interrupt mode");

  chk_rst_last: assert property (
    !direct_r && count_r == SRGT_COUNT_LAST && !rst_req_r && !sys_rst_i |=> sys_rst_req_o)
    else $error("no reset request at count -16");

  chk_rst_direct: assert property (
    direct_r && count_r == SRGT_COUNT_NMI && !rst_req_r && !sys_rst_i ##1 1 |-> sys_rst_req_o)
    else $error("no reset request at zero in direct mode");

  chk_rst_reload: assert property (
    sys_rst_req_o |=> count_r == SRGT_COUNT_RST && !direct_r && !sw_frz_r)
    else $error("reset request did not reload the block");

  chk_remap_keep: assert property (
    sys_rst_req_o && !(wr_i && addr_i == SRGT_OFS_REMAP) |=> $stable(remap_r))
    else $error("remap bits lost across reset request");

  chk_direct_sticky: assert property (
    direct_r && !sys_clr |=> direct_r)
    else $error("direct select cleared without system reset");

  chk_sw_frz_direct: assert property (
    direct_r && !core_halted_i && presc_r == 32'h0 && !wr_count && !sys_clr
      |=> count_r == $past(count_r) - 9'h001)
    else $error("software freeze acted in direct mode");

  chk_freeze_set: assert property (
    wr_i && addr_i == SRGT_OFS_FRZ_SET && wdata_i[SRGT_FRZ_BIT] && !direct_r && !sys_clr
      |=> sw_frz_r)
    else $error("freeze-set write did not freeze");

  chk_freeze_clear: assert property (
    wr_i && addr_i == SRGT_OFS_FRZ_CLR && wdata_i[SRGT_FRZ_BIT] |=> !sw_frz_r)
    else $error("freeze-clear write did not resume");

  chk_ctrl_set_only: assert property (
    !direct_r && !(wr_i && addr_i == SRGT_OFS_CTRL && wdata_i[SRGT_CTRL_DIRECT_BIT])
      |=> !direct_r)
    else $error("direct select set without a write of one");

  // Nothing but the halt status and the software freeze may hold back a due tick.
  chk_no_sw_debug: assert property (
    !core_halted_i && !sw_frz_r && presc_r == 32'h0 && !wr_count && !sys_clr
      |=> count_r == $past(count_r) - 9'h001)
    else $error("count held without halt or software freeze");

  chk_nmi_pulse: assert property (
    nmi_o |=> !nmi_o)
    else $error("nmi longer than one cycle");

  chk_req_pulse: assert property (
    sys_rst_req_o |=> !sys_rst_req_o)
    else $error("reset request longer than one cycle");

  chk_nmi_status: assert property (
    nmi_o |-> irq_stat_r[SRGT_IRQ_NMI_BIT])
    else $error("nmi without its status bit");

  chk_tick_status: assert property (
    tick && !sys_clr |=> irq_stat_r[SRGT_IRQ_TICK_BIT])
    else $error("tick without its status bit");

  chk_read_count: assert property (
    rd_i && addr_i == SRGT_OFS_COUNT |=> rdata_o[SRGT_CW-1:0] == $past(count_r))
    else $error("count read returned a wrong value");

  chk_read_idle: assert property (
    !rd_i |=> rdata_o == '0)
    else $error("read data outside the read cycle");

  // Main scenarios: reset after the interrupt, handler rescue, direct reset, freeze.
  cov_nmi_then_reset: cover property (nmi_o ##[1:300] sys_rst_req_o);
  cov_handler_rescue: cover property (nmi_o ##[1:300] wr_count);
  cov_direct_reset: cover property (direct_r ##1 sys_rst_req_o);
  cov_sw_freeze: cover property (sw_frz_r && !direct_r ##1 !sw_frz_r);
  cov_guard_write: cover property (wr_i && addr_i == SRGT_OFS_COUNT && !guard_ok);

endmodule : srgt_guard_timer

/* srgt_core_model.sv */
// Model of the processor core and system reset logic that sit around the guard timer.
module srgt_core_model (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Commands from the bench and requests from the timer.
  input wire logic halt_cmd_i,
  input wire logic sys_rst_req_i,
  // Towards the timer.
  output logic core_halted_o,
  output logic sys_rst_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // The reset logic echoes a request as a one-cycle system reset, as the real controller would.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      core_halted_o <= 1'b0;
      sys_rst_o <= 1'b0;
    end else begin
      core_halted_o <= halt_cmd_i;
      sys_rst_o <= sys_rst_req_i;
    end
  end
endmodule : srgt_core_model

/* srgt_guard_timer_bench.sv */
// Self-checking bench for the runaway guard timer.
module srgt_guard_timer_bench;
  import srgt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TICK = 8;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic halt_cmd = 1'b0;
  logic sys_rst_i;
  logic core_halted_i;
  logic [SRGT_AW-1:0] addr_i = '0;
  logic [SRGT_DW-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [SRGT_DW-1:0] rdata_o;
  logic nmi_o;
  logic sys_rst_req_o;
  logic irq_o;
  logic [SRGT_REMAP_W-1:0] boot_remap_bits_o;
  int num_errors = 0;
  int num_checks = 0;
  int nmi_cnt = 0;
  int rst_cnt = 0;
  realtime t_nmi;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (nmi_o === 1'b1) nmi_cnt++;
  always @(posedge clk_i) if (sys_rst_req_o === 1'b1) rst_cnt++;
  srgt_guard_timer #(.TICK_CYCLES(TICK)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .sys_rst_i(sys_rst_i), .core_halted_i(core_halted_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .nmi_o(nmi_o), .sys_rst_req_o(sys_rst_req_o),
    .irq_o(irq_o), .boot_remap_bits_o(boot_remap_bits_o));
  srgt_core_model core (.clk_i(clk_i), .rst_b_i(rst_b_i), .halt_cmd_i(halt_cmd),
    .sys_rst_req_i(sys_rst_req_o), .core_halted_o(core_halted_i), .sys_rst_o(sys_rst_i));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp, input string what);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(what, rdata_o, exp);
  endtask : rd_chk
  // Waits up to lim edges for the selected pulse; a miss counts as a mismatch.
  task automatic wait_pulse(input bit want_rst, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge clk_i);
      #1 if ((want_rst ? sys_rst_req_o : nmi_o) === 1'b1) break;
    end
    check(want_rst ? "reset request" : "nmi", 16'(n < lim), 16'h0001);
  endtask : wait_pulse
  task automatic test_write_guard();
    wr(SRGT_OFS_FRZ_SET, 16'h0001);
    wr(SRGT_OFS_COUNT, 16'h0040);
    rd_chk(SRGT_OFS_COUNT, 16'h0040, "count");
    wr(SRGT_OFS_COUNT, 16'hFE33);
    rd_chk(SRGT_OFS_COUNT, 16'h0040, "guarded count");
    repeat (3 * TICK) @(posedge clk_i);
    rd_chk(SRGT_OFS_STATE, 16'h0001, "state");
    rd_chk(SRGT_OFS_COUNT, 16'h0040, "frozen count");
    $display("test_write_guard done");
  endtask : test_write_guard
  task automatic test_halt();
    @(posedge clk_i);
    halt_cmd <= 1'b1;
    wr(SRGT_OFS_FRZ_CLR, 16'h0001);
    repeat (3 * TICK) @(posedge clk_i);
    rd_chk(SRGT_OFS_STATE, 16'h0002, "halt state");
    rd_chk(SRGT_OFS_COUNT, 16'h0040, "halted count");
    @(posedge clk_i);
    halt_cmd <= 1'b0;
    $display("test_halt done");
  endtask : test_halt
  task automatic test_nmi_reset();
    wr(SRGT_OFS_FRZ_SET, 16'h0001);
    wr(SRGT_OFS_IRQ_EN, 16'h0001);
    wr(SRGT_OFS_REMAP, 16'h0002);
    wr(SRGT_OFS_COUNT, 16'h0001);
    wr(SRGT_OFS_FRZ_CLR, 16'h0001);
    wait_pulse(1'b0, 2 * TICK + 4);
    t_nmi = $realtime;
    @(posedge clk_i);
    #1 check("irq", 16'(irq_o), 16'h0001);
    rd_chk(SRGT_OFS_IRQ_STAT, 16'h0003, "irq status");
    wr(SRGT_OFS_IRQ_CLR, 16'h0001);
    @(posedge clk_i);
    #1 check("irq cleared", 16'(irq_o), 16'h0000);
    // Read halfway between the first two ticks after the interrupt.
    repeat (TICK / 2) @(posedge clk_i);
    rd_chk(SRGT_OFS_COUNT, 16'h01FF, "negative count");
    wait_pulse(1'b1, 16 * TICK + 4);
    check("ticks to reset", 16'(int'(($realtime - t_nmi) / 10.0)), 16'(16 * TICK + 1));
    rd_chk(SRGT_OFS_COUNT, 16'h00FF, "count after reset");
    rd_chk(SRGT_OFS_REMAP, 16'h0002, "remap");
    check("remap pins", 16'(boot_remap_bits_o), 16'h0002);
    $display("test_nmi_reset done");
  endtask : test_nmi_reset
  task automatic test_direct();
    int n0;
    wr(SRGT_OFS_CTRL, 16'h0001);
    wr(SRGT_OFS_CTRL, 16'h0000);
    rd_chk(SRGT_OFS_CTRL, 16'h0001, "direct select");
    wr(SRGT_OFS_FRZ_SET, 16'h0001);
    rd_chk(SRGT_OFS_STATE, 16'h0000, "direct freeze");
    n0 = nmi_cnt;
    wr(SRGT_OFS_COUNT, 16'h0001);
    wait_pulse(1'b1, TICK + 4);
    check("direct nmi", 16'(nmi_cnt - n0), 16'h0000);
    rd_chk(SRGT_OFS_CTRL, 16'h0000, "select after reset");
    $display("test_direct done");
  endtask : test_direct
  task automatic test_rescue();
    int r0;
    wr(SRGT_OFS_COUNT, 16'h0001);
    wait_pulse(1'b0, 2 * TICK + 4);
    r0 = rst_cnt;
    wr(SRGT_OFS_COUNT, 16'h0080);
    repeat (16 * TICK + 4) @(posedge clk_i);
    check("rescued reset", 16'(rst_cnt - r0), 16'h0000);
    $display("test_rescue done");
  endtask : test_rescue
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    test_write_guard();
    test_halt();
    test_nmi_reset();
    test_direct();
    test_rescue();
    report_and_stop();
  end
endmodule : srgt_guard_timer_bench
